// ===== hdl/adc_port_pkg.sv
// constants, modes and timing for the converter output port block
// assumes one 250 MHz clock and a synchronous active-high reset
// Notes on behaviour
// - self-clocking words shift into two byte registers
// - ready flag rises when registers get new word
// - set ready flag locks out further register loading
// - new word loads only after acknowledge since update
// - rising decimated select sets the ready flag
// - read as one word or two selected bytes
// - decimation select rising marks word complete
// - opened lockout path accepts every update
// - external mode shifts at reader clock rate
// - data ready line shows word available
// - async word is two eleven-bit characters
// - baud divider divides by two to n
// - oscillator gives 19.2 down to 1.2 kHz
// - baud bit clock external or on-board divider
// - word ready drives clear-to-send line
// - decimation gates how often words are sent
// - word ready low only after previous shifted
// - decimation counts two to n plus one
// - word ready high clears count and select
// - self mode drives data and clock when selected
package adc_port_pkg;

  // ----------------------------------------
  // modes and widths
  // ----------------------------------------
  typedef enum logic [1:0] {MODE_SSC, MODE_SEC, MODE_AC} out_mode_t;
  typedef enum logic {ST_IDLE, ST_SHIFT} shift_state_t;

  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int CHAR_BITS = 11;
  localparam int FRAME_BITS = 2 * CHAR_BITS;
  localparam logic [4:0] WORD_BITS_CNT = 5'h10;
  localparam logic [4:0] FRAME_BITS_CNT = 5'h16;
  localparam int DEC_SEL_MAX = 11;
  localparam int DEC_CNT_W = 13;
  localparam int BAUD_SEL_MIN = 8;
  localparam int BAUD_SEL_MAX = 12;
  localparam int OSC_CNT_W = 12;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint CLK_HZ = 250000000;
  localparam longint OSC_HZ = 4915200;
  localparam logic [31:0] OSC_STEP = 32'((OSC_HZ * 64'h1_0000_0000) / CLK_HZ);
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCLK_HALF_NS = 40;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== hdl/word_buffer.sv
// two-entry word buffer with valid/ready on both sides
// assumes the consumer may hold ready low for any time
`timescale 1ns/100ps
module word_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("word_buffer depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } buf_state_t;

  buf_state_t r_reg;
  buf_state_t r_next;
  logic push;
  logic pop;

  assign in_ready_o = (r_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (r_reg.cnt != '0);
  assign out_data_o = r_reg.mem[r_reg.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wr] = in_data_i;
      r_next.wr = r_reg.wr + 1'b1;
    end
    if (pop) begin
      r_next.rd = r_reg.rd + 1'b1;
    end
    r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule // word_buffer

// ===== hdl/adc_output_port.sv
// converter serial output port with parallel capture, decimation and baud divider
// assumes all inputs synchronous to mclk_i; three-state pins resolved outside
`timescale 1ns/100ps
module adc_output_port
  import adc_port_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_CYC,
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // converter words
  input wire logic word_valid_i,
  output logic word_accept_o,
  input wire logic [WORD_W-1:0] word_i,
  // configuration
  input wire out_mode_t mode_i,
  input wire logic dec_route_i,
  input wire logic [3:0] dec_sel_i,
  input wire logic baud_clock_route_i,
  input wire logic [3:0] baud_sel_i,
  input wire logic lockout_enable_i,
  input wire logic byte_mode_i,
  // remote reader
  input wire logic select_line_n_i,
  input wire logic serial_clock_in_i,
  input wire logic data_acknowledge_i,
  input wire logic byte_select_i,
  input wire logic par_read_n_i,
  // serial side
  output logic serial_data_pin_o,
  output logic serial_data_oe_n_o,
  output logic shift_clock_o,
  output logic shift_clock_oe_n_o,
  output logic word_ready_n_o,
  output logic data_ready_line_n_o,
  output logic cts_o,
  output logic decimated_chip_select_n_o,
  // parallel side
  output logic parallel_data_ready_o,
  output logic [WORD_W-1:0] par_data_o,
  output logic par_hi_oe_n_o,
  output logic par_lo_oe_n_o
);

  if (SCLK_HALF < 1 || SCLK_HALF > 255 || BUF_DEPTH < 2) begin : g_chk
    $error("adc_output_port parameters out of range");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    shift_state_t st;
    logic [FRAME_BITS-1:0] shreg;
    logic [4:0] bits_left;
    logic [WORD_W-1:0] out_word;
    logic out_full;
    logic refresh;
    logic word_ready_n_n;
    logic word_ready_n_q;
    logic [DEC_CNT_W-1:0] dec_cnt;
    logic dec_en;
    logic cs_q;
    logic [7:0] tmr;
    logic sclk;
    logic ext_q;
    logic [31:0] osc_acc;
    logic [OSC_CNT_W-1:0] osc_cnt;
    logic cap_en;
    logic captured;
    logic parallel_data_ready;
    logic [BYTE_W-1:0] hi;
    logic [BYTE_W-1:0] lo;
    logic [WORD_W-1:0] par_data;
    logic sd_oe_n;
    logic sc_oe_n;
  } port_state_t;

  port_state_t r_reg;
  port_state_t r_next;
  logic buf_valid;
  logic buf_pop;
  logic [WORD_W-1:0] buf_data;
  logic eff_cs_n;
  logic start;

  function automatic logic [BYTE_W-1:0] rev8(input logic [BYTE_W-1:0] b);
    for (int i = 0; i < BYTE_W; i++) begin
      rev8[i] = b[BYTE_W-1-i];
    end
  endfunction

  function automatic logic [CHAR_BITS-1:0] uart_char(input logic [BYTE_W-1:0] b);
    uart_char = {1'b0, rev8(b), 2'b11};
  endfunction

  function automatic logic [DEC_CNT_W-1:0] dec_target(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > 4'(DEC_SEL_MAX)) ? 4'(DEC_SEL_MAX) : sel;
    dec_target = DEC_CNT_W'(2) << s;
  endfunction

  function automatic logic [OSC_CNT_W-1:0] baud_mask(input logic [3:0] sel);
    logic [3:0] s;
    s = sel;
    if (s < 4'(BAUD_SEL_MIN)) s = 4'(BAUD_SEL_MIN);
    if (s > 4'(BAUD_SEL_MAX)) s = 4'(BAUD_SEL_MAX);
    baud_mask = OSC_CNT_W'((13'h0001 << s) - 13'h0001);
  endfunction

  word_buffer #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_valid_i(word_valid_i),
    .in_ready_o(word_accept_o),
    .in_data_i(word_i),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_data)
  );

  // decimation counter or remote reader drives the select
  assign eff_cs_n = dec_route_i ? !r_reg.dec_en : select_line_n_i;
  assign start = (r_reg.st == ST_IDLE) && r_reg.out_full && !eff_cs_n;
  assign buf_pop = buf_valid && (r_reg.st == ST_IDLE) && !start;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic osc_tick;
    logic baud_tick;
    logic bit_tick;
    logic cap;
    logic half;
    logic pdr_set;
    r_next = r_reg;
    osc_tick = 1'b0;
    baud_tick = 1'b0;
    bit_tick = 1'b0;
    cap = 1'b0;
    half = 1'b0;
    pdr_set = 1'b0;
    r_next.refresh = 1'b0;
    r_next.ext_q = serial_clock_in_i;
    r_next.cs_q = eff_cs_n;
    // oscillator enable and binary baud divider
    {osc_tick, r_next.osc_acc} = {1'b0, r_reg.osc_acc} + {1'b0, OSC_STEP};
    if (osc_tick) begin
      r_next.osc_cnt = r_reg.osc_cnt + 1'b1;
      baud_tick = ((r_reg.osc_cnt & baud_mask(baud_sel_i)) == baud_mask(baud_sel_i));
    end
    // self-clock timer, halves of one bit
    if (r_reg.st == ST_SHIFT && mode_i == MODE_SSC) begin
      if (r_reg.tmr == 8'(SCLK_HALF - 1)) begin
        r_next.tmr = 8'h00;
        half = 1'b1;
        r_next.sclk = !r_reg.sclk;
      end else begin
        r_next.tmr = r_reg.tmr + 8'h01;
      end
    end
    unique case (mode_i)
      MODE_SSC: begin
        bit_tick = half && r_reg.sclk;
        cap = half && !r_reg.sclk;
      end
      MODE_SEC: bit_tick = !serial_clock_in_i && r_reg.ext_q;
      MODE_AC: bit_tick = baud_clock_route_i ? baud_tick : (serial_clock_in_i && !r_reg.ext_q);
      default: bit_tick = 1'b0;
    endcase
    // shifter
    unique case (r_reg.st)
      ST_IDLE: begin
        if (start) begin
          r_next.st = ST_SHIFT;
          r_next.tmr = 8'h00;
          r_next.sclk = 1'b0;
          r_next.captured = 1'b0;
          r_next.cap_en = (mode_i == MODE_SSC) && !(r_reg.parallel_data_ready && lockout_enable_i);
          if (mode_i == MODE_AC) begin
            r_next.shreg = {uart_char(r_reg.out_word[15:8]), uart_char(r_reg.out_word[7:0])};
            r_next.bits_left = FRAME_BITS_CNT;
          end else begin
            r_next.shreg = {r_reg.out_word, 6'h00};
            r_next.bits_left = WORD_BITS_CNT;
          end
        end else if (buf_pop) begin
          r_next.out_word = buf_data;
          r_next.out_full = 1'b1;
          r_next.refresh = r_reg.out_full;
        end
      end
      ST_SHIFT: begin
        if (eff_cs_n) begin
          r_next.st = ST_IDLE;
        end else begin
          if (cap && r_reg.cap_en) begin
            {r_next.hi, r_next.lo} = {r_reg.hi[6:0], r_reg.lo, r_reg.shreg[FRAME_BITS-1]};
            if (r_reg.bits_left == 5'h01) r_next.captured = 1'b1;
          end
          if (bit_tick) begin
            r_next.shreg = {r_reg.shreg[FRAME_BITS-2:0], 1'b1};
            r_next.bits_left = r_reg.bits_left - 5'h01;
            if (r_reg.bits_left == 5'h01) begin
              r_next.st = ST_IDLE;
              r_next.out_full = 1'b0;
            end
          end
        end
      end
    endcase
    r_next.sd_oe_n = (r_next.st != ST_SHIFT);
    r_next.sc_oe_n = !((r_next.st == ST_SHIFT) && (mode_i == MODE_SSC));
    r_next.word_ready_n_n = !r_next.out_full || r_next.refresh;
    r_next.word_ready_n_q = r_reg.word_ready_n_n;
    // decimation counter
    if (!r_reg.word_ready_n_q && r_reg.word_ready_n_n && r_reg.dec_en) begin
      r_next.dec_cnt = '0;
      r_next.dec_en = 1'b0;
    end else if (r_reg.word_ready_n_q && !r_reg.word_ready_n_n && !r_reg.dec_en) begin
      r_next.dec_cnt = r_reg.dec_cnt + 1'b1;
      if (r_next.dec_cnt == dec_target(dec_sel_i)) r_next.dec_en = 1'b1;
    end
    // handshake flag, set wins over acknowledge
    pdr_set = eff_cs_n && !r_reg.cs_q && r_next.captured;
    if (pdr_set) begin
      r_next.parallel_data_ready = 1'b1;
      r_next.captured = 1'b0;
    end else if (data_acknowledge_i) begin
      r_next.parallel_data_ready = 1'b0;
    end
    if (byte_mode_i) begin
      r_next.par_data = {8'h00, byte_select_i ? r_next.hi : r_next.lo};
    end else begin
      r_next.par_data = {r_next.hi, r_next.lo};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.word_ready_n_n <= 1'b1;
      r_reg.word_ready_n_q <= 1'b1;
      r_reg.cs_q <= 1'b1;
      r_reg.sd_oe_n <= 1'b1;
      r_reg.sc_oe_n <= 1'b1;
      r_reg.shreg <= '1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign serial_data_pin_o = r_reg.shreg[FRAME_BITS-1];
  assign serial_data_oe_n_o = r_reg.sd_oe_n;
  assign shift_clock_o = r_reg.sclk;
  assign shift_clock_oe_n_o = r_reg.sc_oe_n;
  assign word_ready_n_o = r_reg.word_ready_n_n;
  assign data_ready_line_n_o = r_reg.word_ready_n_n;
  assign cts_o = r_reg.word_ready_n_n;
  assign decimated_chip_select_n_o = eff_cs_n;
  assign parallel_data_ready_o = r_reg.parallel_data_ready;
  assign par_data_o = r_reg.par_data;
  assign par_hi_oe_n_o = par_read_n_i || byte_mode_i;
  assign par_lo_oe_n_o = par_read_n_i;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  pdr_on_update_a: assert property ($rose(eff_cs_n) && r_reg.captured |=> parallel_data_ready_o)
    else $error("ready flag not set after update");
  lockout_hold_a: assert property (r_reg.st == ST_SHIFT && !r_reg.cap_en |=> $stable({r_reg.hi, r_reg.lo}))
    else $error("locked registers changed");
  lock_by_flag_a: assert property (start && parallel_data_ready_o && !data_acknowledge_i && lockout_enable_i
    |=> !r_reg.cap_en)
    else $error("load allowed without acknowledge");
  no_lock_open_a: assert property (start && mode_i == MODE_SSC && !lockout_enable_i |=> r_reg.cap_en)
    else $error("update refused with lockout open");
  word_ready_n_after_shift_a: assert property ($fell(word_ready_n_o) |-> $past(r_reg.st) == ST_IDLE)
    else $error("word ready fell during shift");
  dec_clear_a: assert property ($rose(r_reg.word_ready_n_n) && r_reg.dec_en |=> r_reg.dec_cnt == '0 && !r_reg.dec_en)
    else $error("decimation not cleared");
  dec_bound_a: assert property (r_reg.dec_cnt <= dec_target(dec_sel_i) || $changed(dec_sel_i))
    else $error("decimation count beyond target");
  ac_frame_a: assert property (start && mode_i == MODE_AC |=> r_reg.bits_left == FRAME_BITS_CNT
    && r_reg.shreg[FRAME_BITS-1] == 1'b0 && r_reg.shreg[CHAR_BITS+1:CHAR_BITS] == 2'b11)
    else $error("bad character frame");
  drive_sel_a: assert property (!serial_data_oe_n_o |-> $past(eff_cs_n) == 1'b0)
    else $error("data driven while deselected");
  byte_read_a: assert property (byte_mode_i && $stable(byte_mode_i) |=> par_data_o[15:8] == 8'h00)
    else $error("upper byte not cleared in byte mode");

  ssc_word_c: cover property (r_reg.captured ##[1:100] parallel_data_ready_o);
  ack_c: cover property (parallel_data_ready_o ##1 data_acknowledge_i ##1 !parallel_data_ready_o);
  ac_done_c: cover property (mode_i == MODE_AC && $rose(word_ready_n_o));
  dec_en_c: cover property ($rose(r_reg.dec_en));
endmodule // adc_output_port

// ===== testbench/reader_model.sv
// remote reader: selects the port, collects serial bits, acknowledges the flag
// assumes self-clocking mode with remote select and one clock mclk_i
`timescale 1ns/100ps
module reader_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // bench control
  input wire logic go_i,
  input wire logic ack_en_i,
  output logic done_o,
  output logic [15:0] got_o,
  // port side
  input wire logic word_ready_n_i,
  input wire logic shift_clock_i,
  input wire logic serial_data_i,
  input wire logic serial_data_oe_n_i,
  input wire logic parallel_data_ready_i,
  output logic select_line_n_o,
  output logic data_acknowledge_o
);
  logic clk_reg;
  logic pend_reg;

  always_ff @(posedge mclk_i) begin
    clk_reg <= shift_clock_i;
    done_o <= 1'b0;
    data_acknowledge_o <= 1'b0;
    if (go_i) pend_reg <= 1'b1;
    if (rst_i) begin
      select_line_n_o <= 1'b1;
      pend_reg <= 1'b0;
      got_o <= 16'h0000;
    end else if (select_line_n_o) begin
      if (pend_reg && !word_ready_n_i) begin
        select_line_n_o <= 1'b0;
        pend_reg <= 1'b0;
        got_o <= 16'h0000;
      end else if (ack_en_i && parallel_data_ready_i && !data_acknowledge_o) begin
        // acknowledge only while deselected, never mid-word
        data_acknowledge_o <= 1'b1;
      end
    end else begin
      if (shift_clock_i && !clk_reg && !serial_data_oe_n_i) begin
        got_o <= {got_o[14:0], serial_data_i};
      end
      // release only once the whole word has left the port
      if (word_ready_n_i) begin
        select_line_n_o <= 1'b1;
        done_o <= 1'b1;
      end
    end
  end
endmodule // reader_model

// ===== testbench/adc_output_port_interface_tb.sv
// self-checking bench for the converter output port, self-clocking and bench-clocked paths
// assumes reader_model on the far side; shift clock shortened to one cycle halves
`timescale 1ns/100ps
module adc_output_port_interface_tb;
  import adc_port_pkg::*;

  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic word_valid = 1'b0;
  logic [15:0] word = 16'h0000;
  out_mode_t mode = MODE_SSC;
  logic [3:0] dec_sel = 4'h0;
  logic dec_route = 1'b0;
  logic serial_clock_in = 1'b0;
  logic [3:0] baud_sel = 4'h8;
  logic lockout = 1'b1;
  logic byte_mode = 1'b0;
  logic byte_sel = 1'b0;
  logic read_n = 1'b1;
  logic go = 1'b0;
  logic ack_en = 1'b0;
  logic accept, sel_n, ack, done, oe_n, converter_serial_out, sclk, wr_n, drl_n, cts, flag, hi_oe_n, lo_oe_n, sclk_oe_n, dcs_n;
  logic [15:0] par, got, w, w0, w3;
  int n_fail = 0;
  int comparisons = 0;
  int waits;

  always #2 mclk_i = ~mclk_i;

  adc_output_port #(.SCLK_HALF(1)) u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .word_valid_i(word_valid), .word_accept_o(accept), .word_i(word),
    .mode_i(mode), .dec_route_i(dec_route), .dec_sel_i(dec_sel), .baud_clock_route_i(1'b0),
    .baud_sel_i(baud_sel), .lockout_enable_i(lockout), .byte_mode_i(byte_mode),
    .select_line_n_i(sel_n), .serial_clock_in_i(serial_clock_in), .data_acknowledge_i(ack),
    .byte_select_i(byte_sel), .par_read_n_i(read_n), .serial_data_pin_o(converter_serial_out),
    .serial_data_oe_n_o(oe_n), .shift_clock_o(sclk), .shift_clock_oe_n_o(sclk_oe_n), .word_ready_n_o(wr_n),
    .data_ready_line_n_o(drl_n), .cts_o(cts), .decimated_chip_select_n_o(dcs_n),
    .parallel_data_ready_o(flag), .par_data_o(par), .par_hi_oe_n_o(hi_oe_n), .par_lo_oe_n_o(lo_oe_n)
  );

  reader_model u_reader (
    .mclk_i(mclk_i), .rst_i(rst_i), .go_i(go), .ack_en_i(ack_en), .done_o(done), .got_o(got),
    .word_ready_n_i(wr_n), .shift_clock_i(sclk), .serial_data_i(converter_serial_out), .serial_data_oe_n_i(oe_n),
    .parallel_data_ready_i(flag), .select_line_n_o(sel_n), .data_acknowledge_o(ack)
  );

  // ----------------------------------------
  // check and drive tasks
  // ----------------------------------------
  task automatic conclude();
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got_v, input logic [15:0] exp_v);
    comparisons++;
    if (got_v !== exp_v) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic chk1(input logic got_v, input logic exp_v);
    comparisons++;
    if (got_v !== exp_v) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge mclk_i);
  endtask

  // bounded wait, sampled mid-cycle
  task automatic waitfor(ref logic s, input logic v);
    waits = 0;
    @(negedge mclk_i);
    while (s !== v) begin
      waits++;
      if (waits > 2000) begin
        n_fail++;
        conclude();
      end
      @(negedge mclk_i);
    end
  endtask

  task automatic send(input logic [15:0] v);
    @(posedge mclk_i);
    word_valid <= 1'b1;
    word <= v;
    waitfor(accept, 1'b1);
    @(posedge mclk_i);
    word_valid <= 1'b0;
  endtask

  task automatic request();
    @(posedge mclk_i);
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
  endtask

  task automatic xfer();
    request();
    waitfor(done, 1'b1);
  endtask

  // one character: start bit, data lsb first, two stop bits
  function automatic logic [10:0] ac_char(input logic [7:0] b);
    ac_char = {1'b0, b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7], 2'b11};
  endfunction

  // bench-clocked word: sci pulses once a bit, pin checked between pulses
  task automatic ext_word(input logic [21:0] f, input int n);
    request();
    waitfor(oe_n, 1'b0);
    chk1(sclk_oe_n, 1'b1);
    for (int k = 0; k < n; k++) begin
      chk1(converter_serial_out, f[21-k]);
      @(posedge mclk_i);
      serial_clock_in <= 1'b1;
      @(posedge mclk_i);
      serial_clock_in <= 1'b0;
      tick(2);
    end
    waitfor(sel_n, 1'b1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(1400));
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    tick(2);
    chk1(flag, 1'b0);
    w0 = 16'($urandom);
    send(w0);
    tick(4);
    chk1(wr_n, 1'b0);
    chk1(drl_n, 1'b0);
    chk1(cts, 1'b0);
    xfer();
    chk16(got, w0);
    chk1(wr_n, 1'b1);
    tick(3);
    chk1(flag, 1'b1);
    @(posedge mclk_i);
    read_n <= 1'b0;
    tick(2);
    chk16(par, w0);
    chk1(hi_oe_n, 1'b0);
    chk1(lo_oe_n, 1'b0);
    // second word without acknowledge must not reach the registers
    w = 16'($urandom);
    send(w);
    tick(4);
    xfer();
    chk16(got, w);
    tick(3);
    chk16(par, w0);
    chk1(flag, 1'b1);
    @(posedge mclk_i);
    ack_en <= 1'b1;
    tick(5);
    chk1(flag, 1'b0);
    @(posedge mclk_i);
    ack_en <= 1'b0;
    w3 = 16'($urandom);
    send(w3);
    tick(4);
    xfer();
    tick(3);
    chk16(par, w3);
    chk1(flag, 1'b1);
    // byte reads
    @(posedge mclk_i);
    byte_mode <= 1'b1;
    byte_sel <= 1'b1;
    tick(3);
    chk16(par, {8'h00, w3[15:8]});
    chk1(hi_oe_n, 1'b1);
    @(posedge mclk_i);
    byte_sel <= 1'b0;
    tick(3);
    chk16(par, {8'h00, w3[7:0]});
    // lockout opened: every update lands though the flag stays set
    @(posedge mclk_i);
    byte_mode <= 1'b0;
    lockout <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h8001 : 16'($urandom);
      send(w);
      tick(4);
      xfer();
      chk16(got, w);
      tick(3);
      chk16(par, w);
    end
    // fill the buffer while a word shifts, then newest word goes out
    w0 = 16'($urandom);
    send(w0);
    tick(4);
    request();
    waitfor(oe_n, 1'b0);
    chk1(sclk_oe_n, 1'b0);
    send(16'($urandom));
    send(16'($urandom));
    w = 16'($urandom);
    send(w);
    chk1(waits > 10, 1'b1);
    chk16(got, w0);
    tick(10);
    xfer();
    chk16(got, w);
    // bench-clocked modes: nothing reaches the parallel registers
    @(posedge mclk_i);
    mode <= MODE_SEC;
    w0 = 16'($urandom);
    send(w0);
    tick(4);
    ext_word({w0, 6'h00}, 16);
    chk16(par, w);
    @(posedge mclk_i);
    mode <= MODE_AC;
    w3 = 16'($urandom);
    send(w3);
    tick(4);
    chk1(cts, 1'b0);
    ext_word({ac_char(w3[15:8]), ac_char(w3[7:0])}, 22);
    chk16(par, w);
    chk1(cts, 1'b1);
    // mid-run reset, then the decimation counter drives the select
    @(posedge mclk_i);
    mode <= MODE_SSC;
    dec_route <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    tick(2);
    chk1(flag, 1'b0);
    chk16(par, 16'h0000);
    chk1(dcs_n, 1'b1);
    w0 = 16'($urandom);
    send(w0);
    tick(4);
    chk1(dcs_n, 1'b1);
    w3 = 16'($urandom);
    send(w3);
    waitfor(dcs_n, 1'b0);
    waitfor(dcs_n, 1'b1);
    tick(3);
    chk16(par, w3);
    chk1(flag, 1'b1);
    conclude();
  end
endmodule // adc_output_port_interface_tb
